// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import timer8_pkg::*;
  logic       clk;
  logic       srst;
  logic       tick;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [1:0] lvl;
  logic [1:0] pin;
  logic [1:0] out;
  logic [1:0] oe_n;
  logic [2:0] fclr;
  logic [2:0] flags;
  logic       irq;
  logic       ce;
  int         num_errors = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         i;

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  timer8_pin_model timer8_pin_model_inst (.i_clk(clk), .i_level(lvl), .o_pin(pin));

  timer8_dual_capture_compare timer8_dual_capture_compare_inst (
    .I_CORE_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_TICK(tick),
    .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wdata),
    .I_CH_IN(pin), .I_FLAG_CLR(fclr), .O_SFR_RDATA(rdata), .O_CH_OUT(out),
    .O_CH_OE_N(oe_n), .O_FLAGS(flags), .O_IRQ(irq));

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 wr = 1;
    addr = a;
    wdata = v;
    @(posedge clk);
    #1 wr = 0;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 rd = 1;
    addr = a;
    @(posedge clk);
    #1 rd = 0;
    chk(n, rdata, e);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 tick = 1;
      @(posedge clk);
      #1 tick = 0;
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic wflag(input int b);
    for (i = 0; i < 400 && flags[b] !== 1'b1; i++) @(posedge clk) #1;
    chk("flag", {7'h00, flags[b]}, 8'h01);
  endtask

  task automatic clrflags;
    @(posedge clk);
    #1 fclr = 3'h7;
    @(posedge clk);
    #1 fclr = 3'h0;
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // whole run is well under 20k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    srst = 1;
    ce = 1;
    tick = 0;
    wr = 0;
    rd = 0;
    addr = 8'h00;
    wdata = 8'h00;
    lvl = 2'h0;
    fclr = 3'h0;
    repeat (6) @(posedge clk);
    #1 srst = 0;
    rchk("ctl rst", ADDR_CTL, 8'h08);
    rchk("cctl0 rst", ADDR_CCTL0, 8'h40);
    rchk("val0 rst", ADDR_VAL0, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    chk("oe_n rst", {6'h00, oe_n}, 8'h03);
    wreg(ADDR_CCTL1, 8'hFF);
    rchk("cctl1 b7", ADDR_CCTL1, 8'h7F);
    wreg(ADDR_CCTL1, 8'h40);
    wreg(ADDR_VAL0, 8'hA5);
    rchk("val0 rw", ADDR_VAL0, 8'hA5);
    for (int c = 0; c < 8; c++) begin
      wreg(ADDR_CTL, {c[2:0], 5'h14});
      ticks((1 << c) - 1);
      rchk("pre hold", ADDR_CNT, 8'h00);
      ticks(1);
      rchk("pre step", ADDR_CNT, 8'h01);
    end
    rchk("clr reads 0", ADDR_CTL, 8'hF4 & 8'hFB);
    wreg(ADDR_CTL, 8'h08);
    ticks(5);
    rchk("stopped", ADDR_CNT, 8'h01);
    wreg(ADDR_CTL, 8'h1C);
    tick = 1;
    wflag(FLAG_OVF);
    @(posedge clk);
    #1 tick = 0;
    rchk("free wrap", ADDR_CNT, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq on", {7'h00, irq}, 8'h01);
    wreg(ADDR_CTL, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", {7'h00, irq}, 8'h00);
    clrflags();
    chk("flags clr", {5'h00, flags}, 8'h00);
    wreg(ADDR_CTL, 8'h14);
    ticks(9);
    // counter frozen at 9 with tick low, so the captured value is exact
    for (int m = 0; m < 4; m++) begin
      wreg(ADDR_CCTL0, {6'h10, m[1:0]});
      for (int e = 0; e < 2; e++) begin
        // fresh zero per edge so a missed capture cannot hide behind the last one
        wreg(ADDR_VAL0, 8'h00);
        lvl[0] = ~lvl[0];
        repeat (6) @(posedge clk);
        d = (m == 3 || m == e + 1) ? 8'h09 : 8'h00;
        chk("cap flag", {7'h00, flags[FLAG_CH0]}, {7'h00, d[0]});
        rchk("cap val", ADDR_VAL0, d);
        clrflags();
      end
    end
    wreg(ADDR_VAL1, 8'h05);
    for (int a = 0; a < 4; a++) begin
      wreg(ADDR_CTL, 8'h14);
      wreg(ADDR_CCTL1, {2'b01, a[2:0], 3'b100});
      ticks(5);
      chk("cmp out", {7'h00, out[1]}, {7'h00, a != 1});
      chk("cmp oe_n", {7'h00, oe_n[1]}, 8'h00);
      chk("cmp flag", {7'h00, flags[2]}, 8'h01);
      clrflags();
    end
    wreg(ADDR_CTL, 8'h14);
    repeat (3) @(posedge clk);
    chk("cmp zero", {7'h00, out[1]}, 8'h00);
    wreg(ADDR_VAL0, 8'h08);
    wreg(ADDR_CCTL0, 8'h74);
    wreg(ADDR_CCTL1, 8'h6C);
    wreg(ADDR_CTL, 8'h14);
    ticks(5);
    chk("ref set", {6'h00, out}, 8'h03);
    // a limit written mid-period must wait for the next zero
    wreg(ADDR_VAL0, 8'h06);
    ticks(1);
    chk("cc0 shadow", {6'h00, out}, 8'h03);
    ticks(2);
    chk("ref clear", {6'h00, out}, 8'h00);
    wreg(ADDR_CCTL1, 8'h64);
    wreg(ADDR_CTL, 8'h14);
    ticks(0);
    chk("zero set", {6'h00, out}, 8'h03);
    ticks(5);
    chk("up clear", {6'h00, out}, 8'h01);
    chk("ch irq", {7'h00, irq}, 8'h01);
    wreg(ADDR_CCTL0, 8'h34);
    wreg(ADDR_CCTL1, 8'h24);
    repeat (2) @(posedge clk);
    chk("ch irq mask", {7'h00, irq}, 8'h00);
    wreg(ADDR_CCTL1, 8'h40);
    wreg(ADDR_VAL0, 8'h03);
    wreg(ADDR_CTL, 8'h16);
    clrflags();
    ticks(4);
    rchk("modulo wrap", ADDR_CNT, 8'h00);
    chk("mod ovf", {7'h00, flags[FLAG_OVF]}, 8'h01);
    wreg(ADDR_CTL, 8'h17);
    ticks(5);
    rchk("updown", ADDR_CNT, 8'h01);
    ce = 0;
    ticks(3);
    #1 ce = 1;
    rchk("ce freeze", ADDR_CNT, 8'h01);
    wreg(ADDR_CTL, 8'h17);
    ticks(1);
    rchk("dir reset", ADDR_CNT, 8'h01);
    wreg(ADDR_CTL, 8'h05);
    wreg(ADDR_CTL, 8'h11);
    ticks(2);
    rchk("down", ADDR_CNT, 8'h01);
    ticks(3);
    rchk("down stays", ADDR_CNT, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- timer8_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer8_channel #(
  parameter bit IS_CH0 = 1'b1
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_srst,
  input  wire logic                        i_ce,
  input  wire logic [7:0]                  i_ctl,
  input  wire logic                        i_pin,
  input  wire logic                        i_run,
  input  wire logic                        i_upd,
  input  wire logic                        i_down,
  input  wire logic                        i_updn,
  input  wire logic [timer8_pkg::CNT_W-1:0] i_cnt,
  input  wire logic [timer8_pkg::CNT_W-1:0] i_cmp,
  input  wire logic [timer8_pkg::CNT_W-1:0] i_ref,
  output logic                             o_capture,
  output logic                             o_match,
  output logic                             o_out,
  output logic                             o_oe_n
);
  import timer8_pkg::*;

  logic             sync1_ff;
  logic             sync2_ff;
  logic             sync3_ff;
  logic             rise;
  logic             fall;
  logic             is_cmp;
  logic [1:0]       cap_sel;
  logic [2:0]       action;
  logic             at_zero;
  logic             at_ref;
  logic             nxt_out;

  assign is_cmp  = i_ctl[CC_FUNC];
  assign cap_sel = i_ctl[CC_CAP_HI:CC_CAP_LO];
  assign action  = i_ctl[CC_CMP_HI:CC_CMP_LO];

  // sync1 feeds only sync2 so the edge detector never sees a metastable bit
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else if (i_ce) begin
      sync1_ff <= i_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign rise = sync2_ff && !sync3_ff;
  assign fall = !sync2_ff && sync3_ff;
  assign o_capture = !is_cmp && i_run && i_ce &&
                     ((cap_sel == CAP_RISE && rise) || (cap_sel == CAP_FALL && fall) ||
                      (cap_sel == CAP_BOTH && (rise || fall)));

  // compare looks once per counter update, so a held count acts only once
  assign o_match = is_cmp && i_upd && (i_cnt == i_cmp);
  assign at_zero = i_upd && (i_cnt == CNT_ZERO);
  assign at_ref  = i_upd && (IS_CH0 ? (i_cnt == ((action == CMP_SET_REF) ? CNT_MAX : CNT_ZERO))
                                    : (i_cnt == i_ref));

  always_comb begin
    nxt_out = o_out;
    case (action)
      CMP_SET: begin
        if (o_match) nxt_out = 1'b1;
      end
      CMP_CLR: begin
        if (o_match) nxt_out = 1'b0;
      end
      CMP_TOG: begin
        if (o_match) nxt_out = !o_out;
      end
      CMP_SET_UP: begin
        if (!i_updn && at_zero) nxt_out = 1'b0;
        if (o_match) nxt_out = (i_updn && i_down) ? 1'b0 : 1'b1;
      end
      CMP_CLR_UP: begin
        if (!i_updn && at_zero) nxt_out = 1'b1;
        if (o_match) nxt_out = (i_updn && i_down) ? 1'b1 : 1'b0;
      end
      CMP_SET_REF: begin
        if (at_ref) nxt_out = 1'b0;
        if (o_match) nxt_out = 1'b1;
      end
      CMP_CLR_REF: begin
        if (at_ref) nxt_out = 1'b1;
        if (o_match) nxt_out = 1'b0;
      end
      default: nxt_out = o_out; // unused code leaves the pin alone
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_out  <= 1'b0;
      o_oe_n <= 1'b1;
    end else if (i_ce) begin
      o_out  <= is_cmp ? nxt_out : o_out;
      o_oe_n <= !is_cmp;
    end
  end

  set_on_match_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_ce && o_match && action == CMP_SET) |=> o_out)
    else $error("set action did not raise output");
endmodule
`default_nettype wire

// ---- timer8_dual_capture_compare.sv ----
// Summary of operation
// - prescale_select bits 7:5 divide tick by 1 up to 128, doubling per code.
// - run bit 4 set counts; cleared holds the present count.
// - overflow_irq_enable bit 3 resets to 1 and gates the overflow request.
// - writing 1 to counter_clear bit 2 zeroes the count; reads as 0.
// - free running mode counts 0x00 to 0xFF and wraps.
// - down mode loads channel 0 value and counts down to 0x00, stays.
// - modulo mode counts 0x00 up to channel 0 value, restarts at 0x00.
// - up/down mode counts up to channel 0 value then down to 0x00.
// - channel function bit 2: 0 capture, 1 compare.
// - edge_trigger_select bits 1:0: off, rising, falling, both edges.
// - compare_action 000 sets, 001 clears, 010 toggles; 111 unused.
// - action 011 sets on up match, clears at zero or down match.
// - action 100 clears on up match, sets at zero or down match.
// - channel 0 action 101 set match, clear 0xFF; 110 clear match, set 0x00.
// - channel 1 actions 101 and 110 use channel 0 value as second point.
// - a match is counter equal to channel value; action applied then.
// - channel_irq_enable bit 6 resets to 1 and gates request; bit 7 reads 0.
// - channel 0 value is 8-bit read/write, resets to 0x00.
// - terminal count sets overflow flag; request only if enabled.
// - selected capture edge while run is set copies count into value register, sets flag.
// - channel 0 compare value takes effect at count 0x00; channel 1 at once.
// - counter_clear also resets count direction to up.
`timescale 1ns/1ps
`default_nettype none
module timer8_dual_capture_compare (
  input  wire logic                            I_CORE_CLK,
  input  wire logic                            I_SRST,
  input  wire logic                            I_CE,
  input  wire logic                            I_TICK,
  input  wire logic [7:0]                      I_SFR_ADDR,
  input  wire logic                            I_SFR_WR,
  input  wire logic                            I_SFR_RD,
  input  wire logic [7:0]                      I_SFR_WDATA,
  input  wire logic [timer8_pkg::NUM_CH-1:0]   I_CH_IN,
  input  wire logic [timer8_pkg::FLAG_W-1:0]   I_FLAG_CLR,
  output logic      [7:0]                      O_SFR_RDATA,
  output logic      [timer8_pkg::NUM_CH-1:0]   O_CH_OUT,
  output logic      [timer8_pkg::NUM_CH-1:0]   O_CH_OE_N,
  output logic      [timer8_pkg::FLAG_W-1:0]   O_FLAGS,
  output logic                                 O_IRQ
);
  import timer8_pkg::*;

  logic [DIV_W-1:0]  div_ff;
  logic              run_ff;
  logic              run_prev_ff;
  logic              ovf_en_ff;
  logic [1:0]        mode_ff;
  logic [7:0]        cctl_ff [NUM_CH];
  logic [CNT_W-1:0]  val_ff [NUM_CH];
  logic [CNT_W-1:0]  cc0_act_ff;
  logic [CNT_W-1:0]  cnt_ff;
  count_dir_e        dir_ff;
  logic              upd_ff;
  logic              step_down_ff;

  logic              wr_ctl;
  logic              clr_pulse;
  logic              step;
  logic              step_en;
  logic              load_down;
  logic [CNT_W-1:0]  nxt_cnt;
  count_dir_e        nxt_dir;
  logic              nxt_down;
  logic              term;
  logic [NUM_CH-1:0] cap_ev;
  logic [NUM_CH-1:0] match_ev;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_en;

  assign wr_ctl    = I_CE && I_SFR_WR && (I_SFR_ADDR == ADDR_CTL);
  assign clr_pulse = wr_ctl && I_SFR_WDATA[CTL_CLR];
  assign step_en   = step && run_ff && I_CE;
  // down mode reloads when the timer is started
  assign load_down = I_CE && run_ff && !run_prev_ff && (mode_ff == MODE_DOWN);

  timer8_prescaler #(
    .DIV_W   (DIV_W),
    .PRESC_W (PRESC_W)
  ) u_presc (
    .i_clk  (I_CORE_CLK),
    .i_srst (I_SRST),
    .i_ce   (I_CE),
    .i_tick (I_TICK),
    .i_clr  (clr_pulse),
    .i_div  (div_ff),
    .o_step (step)
  );

  // timer_control register; the clear bit is a strobe and is not stored
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      div_ff    <= CTL_RST[CTL_DIV_HI:CTL_DIV_LO];
      run_ff    <= CTL_RST[CTL_RUN];
      ovf_en_ff <= CTL_RST[CTL_OVERFLOW_IRQ_ENABLE];
      mode_ff   <= CTL_RST[CTL_MODE_HI:CTL_MODE_LO];
    end else if (wr_ctl) begin
      div_ff    <= I_SFR_WDATA[CTL_DIV_HI:CTL_DIV_LO];
      run_ff    <= I_SFR_WDATA[CTL_RUN];
      ovf_en_ff <= I_SFR_WDATA[CTL_OVERFLOW_IRQ_ENABLE];
      mode_ff   <= I_SFR_WDATA[CTL_MODE_HI:CTL_MODE_LO];
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      run_prev_ff <= 1'b0;
    end else if (I_CE) begin
      run_prev_ff <= run_ff;
    end
  end

  // channel control registers; bit 7 is never stored so it reads as zero
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cctl_ff[i] <= CCTL_RST;
      end
    end else if (I_CE && I_SFR_WR) begin
      if (I_SFR_ADDR == ADDR_CCTL0) begin
        cctl_ff[0] <= I_SFR_WDATA & CC_RW_MASK;
      end else if (I_SFR_ADDR == ADDR_CCTL1) begin
        cctl_ff[1] <= I_SFR_WDATA & CC_RW_MASK;
      end
    end
  end

  // value registers; a capture in the same cycle as a write wins
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      for (int i = 0; i < NUM_CH; i++) begin
        val_ff[i] <= VAL_RST;
      end
    end else if (I_CE) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (cap_ev[i]) begin
          val_ff[i] <= cnt_ff;
        end else if (I_SFR_WR && I_SFR_ADDR == (i == 0 ? ADDR_VAL0 : ADDR_VAL1)) begin
          val_ff[i] <= I_SFR_WDATA;
        end
      end
    end
  end

  // shadow of the channel 0 value, only refreshed at count zero so a
  // running period never sees a half-applied limit
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      cc0_act_ff <= VAL_RST;
    end else if (I_CE && cnt_ff == CNT_ZERO) begin
      cc0_act_ff <= val_ff[0];
    end
  end

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_dir  = dir_ff;
    nxt_down = 1'b0;
    term     = 1'b0;
    case (mode_ff)
      MODE_FREE: begin
        nxt_cnt = cnt_ff + CNT_ONE;
        term    = (nxt_cnt == CNT_MAX);
      end
      MODE_DOWN: begin
        nxt_down = 1'b1;
        if (cnt_ff != CNT_ZERO) begin
          nxt_cnt = cnt_ff - CNT_ONE;
          term    = (nxt_cnt == CNT_ZERO);
        end
      end
      MODE_MOD: begin
        if (cnt_ff == cc0_act_ff) begin
          nxt_cnt = CNT_ZERO;
          term    = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + CNT_ONE;
        end
      end
      default: begin
        if (dir_ff == DIR_UP) begin
          if (cnt_ff == cc0_act_ff) begin
            nxt_dir  = DIR_DOWN;
            nxt_down = 1'b1;
            nxt_cnt  = (cnt_ff == CNT_ZERO) ? CNT_ZERO : cnt_ff - CNT_ONE;
          end else begin
            nxt_cnt = cnt_ff + CNT_ONE;
          end
        end else if (cnt_ff == CNT_ZERO) begin
          nxt_dir = DIR_UP;
          nxt_cnt = cnt_ff + ((cc0_act_ff == CNT_ZERO) ? CNT_ZERO : CNT_ONE);
        end else begin
          nxt_down = 1'b1;
          nxt_cnt  = cnt_ff - CNT_ONE;
          if (nxt_cnt == CNT_ZERO) begin
            nxt_dir = DIR_UP;
            term    = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      cnt_ff       <= CNT_ZERO;
      dir_ff       <= DIR_UP;
      upd_ff       <= 1'b0;
      step_down_ff <= 1'b0;
    end else if (I_CE) begin
      upd_ff <= clr_pulse || load_down || step_en;
      if (clr_pulse) begin
        cnt_ff       <= CNT_ZERO;
        dir_ff       <= DIR_UP;
        step_down_ff <= 1'b0;
      end else if (load_down) begin
        cnt_ff       <= val_ff[0];
        step_down_ff <= 1'b1;
      end else if (step_en) begin
        cnt_ff       <= nxt_cnt;
        dir_ff       <= nxt_dir;
        step_down_ff <= nxt_down;
      end
    end
  end

  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      timer8_channel #(
        .IS_CH0 (ch == 0)
      ) u_ch (
        .i_clk     (I_CORE_CLK),
        .i_srst    (I_SRST),
        .i_ce      (I_CE),
        .i_ctl     (cctl_ff[ch]),
        .i_pin     (I_CH_IN[ch]),
        .i_run     (run_ff),
        .i_upd     (upd_ff && I_CE),
        .i_down    (step_down_ff),
        .i_updn    (mode_ff == MODE_UPDN),
        .i_cnt     (cnt_ff),
        .i_cmp     ((ch == 0) ? cc0_act_ff : val_ff[ch]),
        .i_ref     (cc0_act_ff),
        .o_capture (cap_ev[ch]),
        .o_match   (match_ev[ch]),
        .o_out     (O_CH_OUT[ch]),
        .o_oe_n    (O_CH_OE_N[ch])
      );
      assign flag_set[FLAG_CH0+ch] = cap_ev[ch] || match_ev[ch];
      assign flag_en[FLAG_CH0+ch]  = cctl_ff[ch][CC_IM];
    end
  endgenerate

  assign flag_set[FLAG_OVF] = step_en && !clr_pulse && !load_down && term;
  assign flag_en[FLAG_OVF]  = ovf_en_ff;

  // a new event outweighs a clear arriving in the same cycle
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_FLAGS <= '0;
    end else if (I_CE) begin
      O_FLAGS <= flag_set | (O_FLAGS & ~I_FLAG_CLR);
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_IRQ <= 1'b0;
    end else if (I_CE) begin
      O_IRQ <= |(O_FLAGS & flag_en);
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_SFR_RDATA <= RD_NONE;
    end else if (I_CE && I_SFR_RD) begin
      if (I_SFR_ADDR == ADDR_CNT) begin
        O_SFR_RDATA <= cnt_ff;
      end else if (I_SFR_ADDR == ADDR_CTL) begin
        O_SFR_RDATA <= {div_ff, run_ff, ovf_en_ff, 1'b0, mode_ff};
      end else if (I_SFR_ADDR == ADDR_CCTL0) begin
        O_SFR_RDATA <= cctl_ff[0];
      end else if (I_SFR_ADDR == ADDR_VAL0) begin
        O_SFR_RDATA <= val_ff[0];
      end else if (I_SFR_ADDR == ADDR_CCTL1) begin
        O_SFR_RDATA <= cctl_ff[1];
      end else if (I_SFR_ADDR == ADDR_VAL1) begin
        O_SFR_RDATA <= val_ff[1];
      end else begin
        O_SFR_RDATA <= RD_NONE;
      end
    end
  end

  clr_zero_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    clr_pulse |=> (cnt_ff == CNT_ZERO) ##1 (upd_ff == 1'b0 || cnt_ff <= CNT_ONE))
    else $error("clear did not zero the counter");

  clr_dir_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    clr_pulse |=> dir_ff == DIR_UP)
    else $error("clear did not restore up direction");

  stop_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (!run_ff && !clr_pulse) |=> $stable(cnt_ff))
    else $error("counter moved while stopped");

  free_wrap_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (step_en && !clr_pulse && mode_ff == MODE_FREE && cnt_ff == CNT_MAX) |=> cnt_ff == CNT_ZERO)
    else $error("free running count did not wrap");

  down_floor_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (step_en && !clr_pulse && !load_down && mode_ff == MODE_DOWN && cnt_ff == CNT_ZERO)
    |=> cnt_ff == CNT_ZERO)
    else $error("down count left zero");

  mod_restart_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (step_en && !clr_pulse && mode_ff == MODE_MOD && cnt_ff == cc0_act_ff)
    |=> cnt_ff == CNT_ZERO && O_FLAGS[FLAG_OVF])
    else $error("modulo count did not restart");

  overflow_irq_enable_reset_a: assert property (@(posedge I_CORE_CLK)
    I_SRST |=> ovf_en_ff && cctl_ff[0][CC_IM] && cctl_ff[1][CC_IM])
    else $error("interrupt enables not set by reset");

  irq_gate_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (I_CE && |(O_FLAGS & flag_en)) |=> O_IRQ)
    else $error("enabled flag raised no request");

  capture_copy_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    cap_ev[0] |=> val_ff[0] == $past(cnt_ff) && O_FLAGS[FLAG_CH0])
    else $error("capture did not store the count");
endmodule
`default_nettype wire

// ---- timer8_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer8_pin_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_level,
  output logic      [1:0] o_pin
);
  initial o_pin = 2'b00;
  // pad edges settle just after a clock edge, never on it
  always @(posedge i_clk) o_pin <= #1 i_level;
endmodule
`default_nettype wire

// ---- timer8_pkg.sv ----
package timer8_pkg;
  localparam int          CNT_W        = 8;
  localparam int          NUM_CH       = 2;
  localparam int          DIV_W        = 3;
  localparam int          PRESC_W      = 7;
  localparam int          FLAG_W       = 3;
  localparam int          FLAG_OVF     = 0;
  localparam int          FLAG_CH0     = 1;

  // register addresses in the special function register space
  localparam logic [7:0]  ADDR_CNT     = 8'hCA;
  localparam logic [7:0]  ADDR_CTL     = 8'hCB;
  localparam logic [7:0]  ADDR_CCTL0   = 8'hCC;
  localparam logic [7:0]  ADDR_VAL0    = 8'hCD;
  localparam logic [7:0]  ADDR_CCTL1   = 8'hCE;
  localparam logic [7:0]  ADDR_VAL1    = 8'hCF;

  // timer_control fields
  localparam int          CTL_DIV_HI   = 7;
  localparam int          CTL_DIV_LO   = 5;
  localparam int          CTL_RUN      = 4;
  localparam int          CTL_OVERFLOW_IRQ_ENABLE    = 3;
  localparam int          CTL_CLR      = 2;
  localparam int          CTL_MODE_HI  = 1;
  localparam int          CTL_MODE_LO  = 0;

  // channel control fields
  localparam int          CC_IM        = 6;
  localparam int          CC_CMP_HI    = 5;
  localparam int          CC_CMP_LO    = 3;
  localparam int          CC_FUNC      = 2;
  localparam int          CC_CAP_HI    = 1;
  localparam int          CC_CAP_LO    = 0;
  localparam logic [7:0]  CC_RW_MASK   = 8'h7F;

  localparam logic [7:0]  CTL_RST      = 8'h08;
  localparam logic [7:0]  CCTL_RST     = 8'h40;
  localparam logic [7:0]  VAL_RST      = 8'h00;
  localparam logic [7:0]  RD_NONE      = 8'h00;
  localparam logic [7:0]  CNT_ZERO     = 8'h00;
  localparam logic [7:0]  CNT_MAX      = 8'hFF;
  localparam logic [7:0]  CNT_ONE      = 8'h01;

  localparam logic [1:0]  MODE_FREE    = 2'h0;
  localparam logic [1:0]  MODE_DOWN    = 2'h1;
  localparam logic [1:0]  MODE_MOD     = 2'h2;
  localparam logic [1:0]  MODE_UPDN    = 2'h3;

  localparam logic [1:0]  CAP_OFF      = 2'h0;
  localparam logic [1:0]  CAP_RISE     = 2'h1;
  localparam logic [1:0]  CAP_FALL     = 2'h2;
  localparam logic [1:0]  CAP_BOTH     = 2'h3;

  localparam logic [2:0]  CMP_SET      = 3'h0;
  localparam logic [2:0]  CMP_CLR      = 3'h1;
  localparam logic [2:0]  CMP_TOG      = 3'h2;
  localparam logic [2:0]  CMP_SET_UP   = 3'h3;
  localparam logic [2:0]  CMP_CLR_UP   = 3'h4;
  localparam logic [2:0]  CMP_SET_REF  = 3'h5;
  localparam logic [2:0]  CMP_CLR_REF  = 3'h6;

  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_e;
endpackage

// ---- timer8_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer8_prescaler #(
  parameter int DIV_W   = timer8_pkg::DIV_W,
  parameter int PRESC_W = timer8_pkg::PRESC_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_ce,
  input  wire logic             i_tick,
  input  wire logic             i_clr,
  input  wire logic [DIV_W-1:0] i_div,
  output logic                  o_step
);
  import timer8_pkg::*;

  logic [PRESC_W-1:0] presc_ff;
  logic [PRESC_W-1:0] mask;

  // divide by 2**div: step on the tick that completes the low bits
  assign mask   = PRESC_W'((1 << i_div) - 1);
  assign o_step = i_tick && ((presc_ff & mask) == mask);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      presc_ff <= '0;
    end else if (i_ce) begin
      if (i_clr) begin
        presc_ff <= '0;
      end else if (i_tick) begin
        presc_ff <= presc_ff + PRESC_W'(1);
      end
    end
  end

  div_one_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_div == '0 && i_tick) |-> o_step)
    else $error("divide by one missed a tick");
endmodule
`default_nettype wire
